// File: lsu_consts.svh
// Constants for the load/store address unit
// Operation
// - Address form: program counter plus signed immediate
// - Address-form immediate spans -4095 to 4095
// - Extend byte/halfword loads; signed only for loads
// - Offset mode: base plus/minus immediate, no writeback
// - Pre-indexed: offset address used and written back
// - Post-indexed: base address used, sum written back
// - Single access immediates -255..4095 or -255..255
// - Two-word immediates multiple of 4, -1020..1020
// - Second word follows; writeback after both
// - Counter load of a single word branches with bit zero cleared
// - Condition flags are never modified
// - Register offset: base plus index shifted 0..3
// - Register offset: no two-word form
// - No condition suffix means always execute
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH
`define LSU_PC_IDX        4'hF
`define LSU_IMM_ADR_MAX   12'hFFF
`define LSU_IMM_OFS_MAX   12'hFFF
`define LSU_IMM_NEG_MAX   12'h0FF
`define LSU_IMM_IDX_MAX   12'h0FF
`define LSU_IMM_PAIR_MAX  12'h3FC
`define LSU_WORD_STEP     32'h0000_0004
`endif

// File: lsu_pkg.sv
// Types for the load/store address unit
package lsu_pkg;
  typedef enum logic [2:0] {OP_ADDR_FORM, OP_LOAD, OP_STORE, OP_LOAD2, OP_STORE2} op_e;
  typedef enum logic [2:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_SBYTE, SZ_SHALF} size_e;
  typedef enum logic [1:0] {MD_OFFSET, MD_PRE, MD_POST, MD_REGOFF} mode_e;
  typedef struct packed {
    op_e         op;
    size_e       size;
    mode_e       mode;
    logic        subtract;
    logic [11:0] imm;
    logic [1:0]  left_shift_amount;
    logic        has_cond;
    logic        cond_pass;
    logic [3:0]  transfer_register;
    logic [3:0]  second_transfer_register;
    logic [3:0]  base_register;
    logic [31:0] base_val;
    logic [31:0] index_val;
    logic [31:0] pc_val;
    logic [31:0] wdata1;
    logic [31:0] wdata2;
  } req_s;
  typedef struct packed {
    logic        write;
    size_e       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;
endpackage

// File: load_extend.sv
// Zero or sign extension of loaded bytes and halfwords
`timescale 1ns/10ps
module load_extend
  import lsu_pkg::*;
(
  input  wire size_e       i_size,
  input  wire logic [31:0] i_raw,
  output logic      [31:0] o_ext
);
  // ==================================================
  // Extension
  always_comb begin
    case (i_size)
      SZ_BYTE:  o_ext = {24'h000000, i_raw[7:0]};
      SZ_HALF:  o_ext = {16'h0000, i_raw[15:0]};
      SZ_SBYTE: o_ext = {{24{i_raw[7]}}, i_raw[7:0]};
      SZ_SHALF: o_ext = {{16{i_raw[15]}}, i_raw[15:0]};
      default:  o_ext = i_raw;
    endcase
  end
endmodule

// File: load_store_address_unit.sv
// Load/store address generation, sequencing and result writeback
`timescale 1ns/10ps
`include "lsu_consts.svh"
module load_store_address_unit
  import lsu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req_valid,
  input  wire req_s        i_req,
  output logic             o_req_ready,
  output logic             o_mem_valid,
  output mem_req_s         o_mem_req,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  output logic             o_rf_we,
  output logic      [3:0]  o_rf_idx,
  output logic      [31:0] o_rf_data,
  output logic             o_wb_we,
  output logic      [3:0]  o_wb_idx,
  output logic      [31:0] o_wb_data,
  output logic             o_branch,
  output logic      [31:0] o_branch_target,
  output logic             o_flags_we,
  output logic             o_fault,
  output logic             o_done
);
  // ==================================================
  // Address helpers
  typedef enum {ST_IDLE, ST_ACC1, ST_ACC2, ST_FINISH} state_e;

  function automatic logic [31:0] offset_of(input req_s r);
    logic [31:0] mag;
    mag = {20'h00000, r.imm};
    if ((r.mode == MD_REGOFF) && (r.op != OP_ADDR_FORM))
      offset_of = r.index_val << r.left_shift_amount;
    else if (r.subtract)
      offset_of = 32'h0000_0000 - mag;
    else
      offset_of = mag;
  endfunction

  function automatic logic [31:0] access_addr(input req_s r);
    if (r.mode == MD_POST)
      access_addr = r.base_val;
    else
      access_addr = r.base_val + offset_of(r);
  endfunction

  // Range checks on the offset magnitude and operand forms
  function automatic logic is_legal(input req_s r);
    logic pair;
    logic is_signed;
    pair      = (r.op == OP_LOAD2) || (r.op == OP_STORE2);
    is_signed = (r.size == SZ_SBYTE) || (r.size == SZ_SHALF);
    if (r.op == OP_ADDR_FORM)
      is_legal = (r.imm <= `LSU_IMM_ADR_MAX);
    else if (pair)
      is_legal = (r.mode != MD_REGOFF) && (r.imm[1:0] == 2'h0)
                 && (r.imm <= `LSU_IMM_PAIR_MAX);
    else if (is_signed && (r.op == OP_STORE))
      is_legal = 1'b0;
    else if (r.mode == MD_REGOFF)
      is_legal = 1'b1;
    else if (r.mode == MD_OFFSET)
      is_legal = r.subtract ? (r.imm <= `LSU_IMM_NEG_MAX) : (r.imm <= `LSU_IMM_OFS_MAX);
    else
      is_legal = (r.imm <= `LSU_IMM_IDX_MAX);
  endfunction

  // ==================================================
  // State
  state_e      state_r, state_nxt;
  req_s        req_r, req_nxt;
  logic        ready_r, ready_nxt;
  logic        mem_valid_r, mem_valid_nxt;
  mem_req_s    mem_r, mem_nxt;
  logic        rf_we_r, rf_we_nxt;
  logic [3:0]  rf_idx_r, rf_idx_nxt;
  logic [31:0] rf_data_r, rf_data_nxt;
  logic        wb_we_r, wb_we_nxt;
  logic [31:0] wb_data_r, wb_data_nxt;
  logic        br_r, br_nxt;
  logic [31:0] br_tgt_r, br_tgt_nxt;
  logic        fault_r, fault_nxt;
  logic        done_r, done_nxt;
  logic [31:0] ext_data;
  logic        take;
  logic        exec_in;
  logic        load_r;
  logic        pair_r;

  load_extend u_ext (
    .i_size (req_r.size),
    .i_raw  (i_mem_rdata),
    .o_ext  (ext_data)
  );

  assign take    = (state_r == ST_IDLE) && ready_r && i_req_valid;
  assign exec_in = !i_req.has_cond || i_req.cond_pass;
  assign load_r  = (req_r.op == OP_LOAD) || (req_r.op == OP_LOAD2);
  assign pair_r  = (req_r.op == OP_LOAD2) || (req_r.op == OP_STORE2);

  // ==================================================
  // Next state
  always_comb begin
    state_nxt     = state_r;
    req_nxt       = req_r;
    mem_valid_nxt = mem_valid_r;
    mem_nxt       = mem_r;
    rf_idx_nxt    = rf_idx_r;
    rf_data_nxt   = rf_data_r;
    wb_data_nxt   = wb_data_r;
    br_tgt_nxt    = br_tgt_r;
    rf_we_nxt     = 1'b0;
    wb_we_nxt     = 1'b0;
    br_nxt        = 1'b0;
    fault_nxt     = 1'b0;
    done_nxt      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          req_nxt = i_req;
          if (!exec_in) begin
            done_nxt = 1'b1;
          end else if (!is_legal(i_req)) begin
            fault_nxt = 1'b1;
            done_nxt  = 1'b1;
          end else if (i_req.op == OP_ADDR_FORM) begin
            rf_we_nxt   = 1'b1;
            rf_idx_nxt  = i_req.transfer_register;
            rf_data_nxt = i_req.pc_val + offset_of(i_req);
            done_nxt    = 1'b1;
          end else begin
            mem_valid_nxt = 1'b1;
            mem_nxt.write = (i_req.op == OP_STORE) || (i_req.op == OP_STORE2);
            mem_nxt.size  = ((i_req.op == OP_LOAD2) || (i_req.op == OP_STORE2)) ? SZ_WORD : i_req.size;
            mem_nxt.addr  = access_addr(i_req);
            mem_nxt.wdata = i_req.wdata1;
            state_nxt     = ST_ACC1;
          end
        end
      end
      ST_ACC1: begin
        if (i_mem_ack) begin
          if (load_r) begin
            if ((req_r.transfer_register == `LSU_PC_IDX) && (req_r.size == SZ_WORD) && !pair_r) begin
              br_nxt     = 1'b1;
              br_tgt_nxt = {i_mem_rdata[31:1], 1'b0};
            end else begin
              rf_we_nxt   = 1'b1;
              rf_idx_nxt  = req_r.transfer_register;
              rf_data_nxt = pair_r ? i_mem_rdata : ext_data;
            end
          end
          if (pair_r) begin
            mem_nxt.addr  = mem_r.addr + `LSU_WORD_STEP;
            mem_nxt.wdata = req_r.wdata2;
            state_nxt     = ST_ACC2;
          end else begin
            mem_valid_nxt = 1'b0;
            state_nxt     = ST_FINISH;
          end
        end
      end
      ST_ACC2: begin
        if (i_mem_ack) begin
          mem_valid_nxt = 1'b0;
          if (load_r) begin
            rf_we_nxt   = 1'b1;
            rf_idx_nxt  = req_r.second_transfer_register;
            rf_data_nxt = i_mem_rdata;
          end
          state_nxt = ST_FINISH;
        end
      end
      ST_FINISH: begin
        // Writeback waits until every transfer has completed
        if ((req_r.mode == MD_PRE) || (req_r.mode == MD_POST)) begin
          wb_we_nxt   = 1'b1;
          wb_data_nxt = req_r.base_val + offset_of(req_r);
        end
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt     = ST_IDLE;
        mem_valid_nxt = 1'b0;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      req_r       <= '0;
      ready_r     <= 1'b0;
      mem_valid_r <= 1'b0;
      mem_r       <= '0;
      rf_we_r     <= 1'b0;
      rf_idx_r    <= 4'h0;
      rf_data_r   <= 32'h0000_0000;
      wb_we_r     <= 1'b0;
      wb_data_r   <= 32'h0000_0000;
      br_r        <= 1'b0;
      br_tgt_r    <= 32'h0000_0000;
      fault_r     <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      req_r       <= req_nxt;
      ready_r     <= ready_nxt;
      mem_valid_r <= mem_valid_nxt;
      mem_r       <= mem_nxt;
      rf_we_r     <= rf_we_nxt;
      rf_idx_r    <= rf_idx_nxt;
      rf_data_r   <= rf_data_nxt;
      wb_we_r     <= wb_we_nxt;
      wb_data_r   <= wb_data_nxt;
      br_r        <= br_nxt;
      br_tgt_r    <= br_tgt_nxt;
      fault_r     <= fault_nxt;
      done_r      <= done_nxt;
    end
  end

  // ==================================================
  // Outputs
  // Flags write strobe is held low; no path here touches the flags
  logic flags_we_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_we_r <= 1'b0;
    end else begin
      flags_we_r <= 1'b0;
    end
  end

  assign o_req_ready     = ready_r;
  assign o_mem_valid     = mem_valid_r;
  assign o_mem_req       = mem_r;
  assign o_rf_we         = rf_we_r;
  assign o_rf_idx        = rf_idx_r;
  assign o_rf_data       = rf_data_r;
  assign o_wb_we         = wb_we_r;
  assign o_wb_idx        = req_r.base_register;
  assign o_wb_data       = wb_data_r;
  assign o_branch        = br_r;
  assign o_branch_target = br_tgt_r;
  assign o_flags_we      = flags_we_r;
  assign o_fault         = fault_r;
  assign o_done          = done_r;

  // ==================================================
  // Assertions
  sequence s_taken_skip;
    take && !exec_in;
  endsequence
  sequence s_taken_run;
    take && exec_in && is_legal(i_req);
  endsequence

  a_flags_never_written: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_flags_we) else $error("flags write strobe raised");
  a_skip_no_effect: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_taken_skip |=> o_done && !o_mem_valid && !o_rf_we && !o_wb_we && !o_branch)
    else $error("failed condition still had an effect");
  a_uncond_executes: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (take && !i_req.has_cond && is_legal(i_req) && (i_req.op == OP_LOAD)) |=> o_mem_valid)
    else $error("unconditional load did not start");
  a_adr_result_sum: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_taken_run and (i_req.op == OP_ADDR_FORM))
    |=> o_rf_we && (o_rf_data == $past(i_req.pc_val) + ($past(i_req.subtract) ?
        32'h0000_0000 - {20'h00000, $past(i_req.imm)} : {20'h00000, $past(i_req.imm)})))
    else $error("address form result wrong");
  a_post_base_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (s_taken_run and (i_req.op != OP_ADDR_FORM) and (i_req.mode == MD_POST))
    |=> o_mem_valid && (o_mem_req.addr == $past(i_req.base_val)))
    else $error("post-indexed access not at base");
  a_offset_no_wb: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_done && (req_r.mode == MD_OFFSET)) |-> !o_wb_we)
    else $error("offset mode wrote the base back");
  a_second_word_next: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_mem_valid && i_mem_ack && pair_r && (state_r == ST_ACC1))
    |=> o_mem_valid && (o_mem_req.addr == $past(o_mem_req.addr) + `LSU_WORD_STEP) && !o_wb_we)
    else $error("second word not at following address");
  a_branch_bit0_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_branch |-> (o_branch_target[0] == 1'b0) && !o_rf_we)
    else $error("branch target bit zero set");
  a_illegal_faults: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (take && exec_in && !is_legal(i_req)) |=> o_fault && o_done && !o_mem_valid)
    else $error("illegal offset not refused");
endmodule

// File: mem_partner.sv
// Behavioural memory answering the unit's beats after a chosen wait
`timescale 1ns/10ps
module mem_partner
  import lsu_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire mem_req_s   i_req,
  input  wire logic [1:0] i_delay,
  output logic            o_ack,
  output logic     [31:0] o_rdata
);
  // ==========================================
  // Beat timing
  logic [1:0]  wait_r;
  logic [31:0] junk_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack  <= 1'b0;
      wait_r <= 2'h0;
      junk_r <= 32'hA5A5_0F0F;
    end else begin
      junk_r <= junk_r + 32'h9E37_79B9;
      if (o_ack) begin
        o_ack  <= 1'b0;
        wait_r <= 2'h0;
      end else if (i_valid && wait_r >= i_delay) begin
        o_ack <= 1'b1;
      end else if (i_valid) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
  // ==========================================
  // Read data
  // Data only means something with the ack; otherwise it churns so stale reads show
  assign o_rdata = o_ack ? (i_req.addr ^ {i_req.addr[15:0], i_req.addr[31:16]} ^ 32'h5A5A_C3C3) : junk_r;
endmodule

// File: testbench.sv
// Self-checking bench for the load/store address unit
`timescale 1ns/10ps
module testbench;
  import lsu_pkg::*;
  typedef struct packed {
    logic [2:0]  k;
    size_e       s;
    logic [31:0] a;
    logic [31:0] d;
  } note_s;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_req_valid = 1'b0;
  req_s        i_req = '0;
  logic [1:0]  mem_delay = 2'h0;
  logic        o_req_ready, o_mem_valid, i_mem_ack, o_rf_we, o_wb_we, o_branch, o_flags_we, o_fault, o_done;
  mem_req_s    o_mem_req;
  logic [31:0] i_mem_rdata, o_rf_data, o_wb_data, o_branch_target;
  logic [3:0]  o_rf_idx, o_wb_idx;
  int          mismatches = 0;
  int          checks = 0;
  note_s       q[$];
  always #2.5 i_core_clk = ~i_core_clk;
  load_store_address_unit u_load_store_address_unit (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_mem_valid(o_mem_valid),
    .o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_rf_we(o_rf_we),
    .o_rf_idx(o_rf_idx), .o_rf_data(o_rf_data), .o_wb_we(o_wb_we), .o_wb_idx(o_wb_idx),
    .o_wb_data(o_wb_data), .o_branch(o_branch), .o_branch_target(o_branch_target),
    .o_flags_we(o_flags_we), .o_fault(o_fault), .o_done(o_done));
  mem_partner u_mem_partner (.i_clk(i_core_clk), .i_rst(i_rst), .i_valid(o_mem_valid), .i_req(o_mem_req),
    .i_delay(mem_delay), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  // ==========================================
  // Checking
  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ {a[15:0], a[31:16]} ^ 32'h5A5A_C3C3;
  endfunction
  function automatic logic [31:0] ext(input size_e s, input logic [31:0] v);
    case (s)
      SZ_BYTE:  return {24'h000000, v[7:0]};
      SZ_HALF:  return {16'h0000, v[15:0]};
      SZ_SBYTE: return {{24{v[7]}}, v[7:0]};
      SZ_SHALF: return {{16{v[15]}}, v[15:0]};
      default:  return v;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Kinds: 0 read, 1 write, 6 write without data check, 2 rf, 3 base, 4 branch, 5 done
  task automatic take(input logic [2:0] k, input logic [31:0] a, input logic [31:0] d);
    note_s n;
    if (q.size() == 0) begin
      mismatches++;
      $display("wrong value result kind expected none seen %0d", k);
      return;
    end
    n = q.pop_front();
    check("result kind", {29'h0, k}, {29'h0, (n.k == 3'h6) ? 3'h1 : n.k});
    check("result field", a, n.a);
    if (n.k != 3'h6 && n.k != 3'h0) check("result data", d, n.d);
    if (k <= 3'h1) check("access size", {29'h0, o_mem_req.size}, {29'h0, n.s});
  endtask
  always @(negedge i_core_clk) begin
    if (!i_rst) begin
      if (o_mem_valid && i_mem_ack) take({2'h0, o_mem_req.write}, o_mem_req.addr, o_mem_req.wdata);
      if (o_rf_we) take(3'h2, {28'h0, o_rf_idx}, o_rf_data);
      if (o_branch) take(3'h4, 32'h0, o_branch_target);
      if (o_wb_we) take(3'h3, {28'h0, o_wb_idx}, o_wb_data);
      if (o_done) take(3'h5, {31'h0, o_fault}, 32'h0);
      if (o_done) check("flag write", {31'h0, o_flags_we}, 32'h0);
    end
  end
  // ==========================================
  // Expected results of one request
  task automatic put(input logic [2:0] k, input logic [31:0] a, input logic [31:0] d, input size_e s);
    note_s n;
    n.k = k;
    n.s = s;
    n.a = a;
    n.d = d;
    q.push_back(n);
  endtask
  task automatic plan(input req_s r);
    logic [31:0] off, a, v;
    logic        pair, fault;
    off = r.subtract ? -{20'h0, r.imm} : {20'h0, r.imm};
    pair = r.op inside {OP_LOAD2, OP_STORE2};
    fault = (r.op == OP_STORE && r.size inside {SZ_SBYTE, SZ_SHALF})
         || (pair && (r.imm[1:0] != 2'h0 || r.imm > 12'h3FC || r.mode == MD_REGOFF))
         || (!pair && r.op != OP_ADDR_FORM && r.mode != MD_REGOFF && r.imm > 12'h0FF
             && (r.subtract || r.mode != MD_OFFSET));
    if (r.has_cond && !r.cond_pass) begin
      put(3'h5, 32'h0, 32'h0, SZ_WORD);
      return;
    end
    if (fault) begin
      put(3'h5, 32'h1, 32'h0, SZ_WORD);
      return;
    end
    if (r.op == OP_ADDR_FORM) begin
      put(3'h2, {28'h0, r.transfer_register}, r.pc_val + off, SZ_WORD);
      put(3'h5, 32'h0, 32'h0, SZ_WORD);
      return;
    end
    a = (r.mode == MD_POST) ? r.base_val : (r.mode == MD_REGOFF) ?
        r.base_val + (r.index_val << r.left_shift_amount) : r.base_val + off;
    for (int i = 0; i < (pair ? 2 : 1); i++) begin
      v = a + (i ? 32'h4 : 32'h0);
      if (r.op inside {OP_STORE, OP_STORE2}) begin
        put(3'h1, v, i ? r.wdata2 : r.wdata1, pair ? SZ_WORD : r.size);
      end else begin
        put(3'h0, v, 32'h0, pair ? SZ_WORD : r.size);
        if (!pair && r.transfer_register == 4'hF && r.size == SZ_WORD)
          put(3'h4, 32'h0, pat(v) & 32'hFFFF_FFFE, SZ_WORD);
        else
          put(3'h2, {28'h0, i ? r.second_transfer_register : r.transfer_register},
              pair ? pat(v) : ext(r.size, pat(v)), SZ_WORD);
      end
    end
    if (r.mode inside {MD_PRE, MD_POST})
      put(3'h3, {28'h0, r.base_register}, r.base_val + off, SZ_WORD);
    put(3'h5, 32'h0, 32'h0, SZ_WORD);
  endtask
  // ==========================================
  // Stimulus
  function automatic req_s rnd(input op_e op, input mode_e md);
    req_s       r;
    logic [1:0] pick;
    r    = '0;
    pick = 2'($urandom);
    r.op                       = op;
    r.mode                     = md;
    r.size                     = size_e'($urandom_range(4, 0));
    r.subtract                 = 1'($urandom);
    r.imm                      = (pick == 2'h0) ? 12'($urandom) :
                                 (pick == 2'h1) ? {2'h0, 8'($urandom), 2'h0} : {4'h0, 8'($urandom)};
    r.left_shift_amount        = 2'($urandom);
    r.has_cond                 = 1'($urandom);
    r.cond_pass                = 1'($urandom);
    r.transfer_register        = 4'($urandom_range(10, 0));
    r.second_transfer_register = r.transfer_register + 4'h1;
    r.base_register            = r.transfer_register + 4'h2;
    r.base_val                 = $urandom;
    r.index_val                = $urandom;
    r.pc_val                   = $urandom;
    r.wdata1                   = $urandom;
    r.wdata2                   = $urandom;
    return r;
  endfunction
  // Valid stays up between calls so back to back requests never toggle it in one step
  task automatic issue(input req_s r);
    plan(r);
    i_req       = r;
    i_req_valid = 1'b1;
    while (!o_req_ready) begin
      @(posedge i_core_clk);
      #1;
    end
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic drain(input string name);
    i_req_valid = 1'b0;
    repeat (24) @(posedge i_core_clk);
    #1;
    check("notes left", 32'(q.size()), 32'h0);
    check("ready when idle", {31'h0, o_req_ready}, 32'h1);
    $display("test %s done", name);
  endtask
  task automatic do_reset(input int cycles);
    i_rst = 1'b1;
    repeat (cycles) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    req_s r;
    void'($urandom(65294));
    do_reset(6);
    for (int i = 0; i < 24; i++) begin
      r           = rnd(OP_ADDR_FORM, mode_e'($urandom_range(3, 0)));
      r.imm[0]    = 1'b0;
      r.pc_val[0] = 1'b1;
      issue(r);
    end
    drain("address form");
    for (int i = 0; i < 64; i++) begin
      mem_delay = 2'($urandom);
      issue(rnd($urandom_range(1, 0) ? OP_LOAD : OP_STORE, mode_e'($urandom_range(3, 0))));
    end
    drain("single access");
    for (int i = 0; i < 32; i++) begin
      mem_delay = 2'($urandom);
      issue(rnd($urandom_range(1, 0) ? OP_LOAD2 : OP_STORE2, mode_e'($urandom_range(3, 0))));
    end
    drain("two-word access");
    for (int i = 0; i < 8; i++) begin
      r                   = rnd(OP_LOAD, mode_e'($urandom_range(3, 0)));
      r.transfer_register = 4'hF;
      r.size              = SZ_WORD;
      r.has_cond          = 1'b0;
      issue(r);
    end
    drain("counter load");
    // Second reset in mid-run, then a mixed burst
    do_reset(3);
    for (int i = 0; i < 16; i++) begin
      issue(rnd(op_e'($urandom_range(4, 0)), mode_e'($urandom_range(3, 0))));
    end
    drain("after reset");
    wrap_up();
  end
  // Tests need at most about 1250 cycles; the limit of 10000 leaves wide margin for slow acks
  initial begin
    #50000;
    mismatches++;
    $display("watchdog expired before the tests ended");
    wrap_up();
  end
endmodule
